// ### hdl/sld_receiver.sv
`timescale 1ns/1ps
module sld_receiver #(
  parameter int LANES       = sld_pkg::WIDE_LANES,
  parameter int LOCK_CYCLES = sld_pkg::LOCK_CYCLES,
  parameter int CLOCK_LOST  = sld_pkg::CLOCK_LOST_CYCLES,
  parameter int FIFO_DEPTH  = sld_pkg::FIFO_DEPTH
) (
  // System clock and reset.
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_n,
  // Serial link pins.
  input  wire logic                                   forwarded_clock_in,
  input  wire logic [LANES-1:0]                       serial_lane_in,
  // Power control.
  input  wire logic                                   sleep_n,
  // Parallel side.
  output logic      [sld_pkg::BITS_PER_CLOCK*LANES-1:0] parallel_word_out,
  output logic                                        regenerated_clock_out,
  output logic                                        link_locked
);

  import sld_pkg::*;

  // Word width and the width of the lock wait counter.
  localparam int WORD   = BITS_PER_CLOCK * LANES;
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

  sld_pins_t          pinRaw;
  sld_pins_t          pinMeta;
  sld_pins_t          pinSync;
  logic               sleepMeta;
  logic               awake;
  logic               clkPrev;
  logic               rise;
  logic [PERIOD_W-1:0] phase;
  logic [PERIOD_W-1:0] phaseNow;
  logic [PERIOD_W-1:0] period;
  logic               present;
  logic [2:0]         bitIdx;
  logic [2:0]         bitIdxNow;
  logic               strobe;
  logic [WORD-1:0]    gather;
  logic [WORD-1:0]    next_gather;
  logic               pendValid;
  logic [WORD-1:0]    pendWord;
  logic               fifoInReady;
  logic               fifoOutValid;
  logic [WORD-1:0]    fifoOutData;
  logic               regenPrev;
  logic               regenFall;
  logic [LOCK_W-1:0]  lockCount;

  // Sample point of bit k spread evenly over the measured period, in system cycles.
  function automatic logic [PERIOD_W-1:0] strobeAt(input logic [2:0] k,
                                                   input logic [PERIOD_W-1:0] per);
    logic [15:0] prod;
    prod = (16'(k) * 16'h0002 + 16'h0001) * 16'(per);
    return PERIOD_W'(prod / 16'h000E);
  endfunction

  // Pins gathered into one bundle; absent lanes of the narrow variant read high.
  always_comb begin
    pinRaw       = '1;
    pinRaw.clk   = forwarded_clock_in;
    pinRaw.lanes[LANES-1:0] = serial_lane_in;
  end

  // Two-stage synchronisers for every pin.
  // Link pins reset to their idle-high failsafe level, so that no false
  // forwarded clock edge is seen when reset is released.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinMeta   <= '1;
      pinSync   <= '1;
      sleepMeta <= 1'b0;
      awake     <= 1'b0;
    end else begin
      pinMeta   <= pinRaw;
      pinSync   <= pinMeta;
      sleepMeta <= sleep_n;
      awake     <= sleepMeta;
    end
  end

  // Rising edge of the synchronised forwarded clock.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clkPrev <= 1'b1; // Matches the idle-high pin.
    end else begin
      clkPrev <= pinSync.clk;
    end
  end

  // One-cycle pulse at each synchronised rise; the phase restarts there.
  assign rise     = pinSync.clk & ~clkPrev;
  assign phaseNow = rise ? '0 : phase;

  // Period measurement and loss-of-clock detection.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase   <= '0;
      period  <= '0;
      present <= 1'b0;
    end else if (rise) begin
      phase   <= PERIOD_W'(1);
      period  <= phase;
      present <= 1'b1;
    end else if (phase != PERIOD_W'(CLOCK_LOST)) begin
      phase <= phase + PERIOD_W'(1);
      if (phase == PERIOD_W'(CLOCK_LOST - 1)) begin
        present <= 1'b0;
      end
    end
  end

  // Lock wait: counts while awake with a running forwarded clock.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !awake || !present) begin
      lockCount   <= '0;
      link_locked <= 1'b0;
    end else if (lockCount != LOCK_W'(LOCK_CYCLES)) begin
      lockCount <= lockCount + LOCK_W'(1);
    end else begin
      link_locked <= 1'b1;
    end
  end

  // Bit strobes: bit 0 first, one strobe per bit per forwarded period.
  assign bitIdxNow = rise ? 3'h0 : bitIdx;
  assign strobe    = present & (bitIdxNow != BIT_IDLE)
                   & (phaseNow == strobeAt(bitIdxNow, period));

  // Each lane's sampled level lands at lane * 7 + bit; idle lanes sample as high.
  always_comb begin
    next_gather = gather;
    // The idle index would point into the next lane, so it writes nothing.
    if (bitIdxNow != BIT_IDLE) begin
      for (int l = 0; l < LANES; l++) begin
        next_gather[l*BITS_PER_CLOCK + int'(bitIdxNow)] = pinSync.lanes[l];
      end
    end
  end

  // Sampler state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bitIdx <= BIT_IDLE;
      gather <= '0;
    end else if (strobe) begin
      bitIdx <= bitIdxNow + 3'h1;
      gather <= next_gather;
    end else if (rise) begin
      bitIdx <= 3'h0;
    end
  end

  // Finished words wait here; a word that finds the slot still full is dropped.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !link_locked) begin
      pendValid <= 1'b0;
      pendWord  <= '0;
    end else if (strobe && bitIdxNow == 3'h6 && (!pendValid || fifoInReady)) begin
      pendValid <= 1'b1;
      pendWord  <= next_gather;
    end else if (fifoInReady) begin
      pendValid <= 1'b0;
    end
  end

  // Word buffer, flushed whenever the link is not locked.
  sld_fifo #(
    .WIDTH (WORD),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flush    (~link_locked),
    .inValid  (pendValid),
    .inData   (pendWord),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (regenFall)
  );

  // Regenerated clock: one cycle behind the synchronised input, low when lost or asleep.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regenerated_clock_out <= 1'b0;
      regenPrev             <= 1'b0;
    end else begin
      regenerated_clock_out <= pinSync.clk & present & awake & link_locked;
      regenPrev             <= regenerated_clock_out;
    end
  end

  // A falling regenerated edge releases the next buffered word.
  assign regenFall = regenPrev & ~regenerated_clock_out;

  // Output word: cleared asleep, updated at falling edges, held when the clock stops.
  // An unlocked link keeps the word already shown rather than one being flushed.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !awake) begin
      parallel_word_out <= '0;
    end else if (regenFall && fifoOutValid && link_locked) begin
      parallel_word_out <= fifoOutData;
    end
  end

endmodule

// ### hdl/sld_pkg.sv
package sld_pkg;

  // Lane counts of the two variants and bits carried per lane per clock.
  localparam int WIDE_LANES     = 4;
  localparam int NARROW_LANES   = 3;
  localparam int MAX_LANES      = 4;
  localparam int BITS_PER_CLOCK = 7;

  // System clock and the long lock wait derived from it.
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_MS      = 10;
  localparam int LOCK_CYCLES       = (LOCK_TIME_MS * 1000000) / SYS_CLK_PERIOD_NS;

  // Forwarded clock taken as lost after this many cycles without a rising edge.
  localparam int CLOCK_LOST_CYCLES = 32;
  localparam int PERIOD_W          = 8;

  // Word buffer between the lane sampler and the output stage.
  localparam int FIFO_DEPTH = 32;

  // Bit index that marks a finished word in the sampler.
  localparam logic [2:0] BIT_IDLE = 3'h7;

  // Forwarded clock and data lanes as they arrive at the pins.
  typedef struct packed {
    logic                 clk;
    logic [MAX_LANES-1:0] lanes;
  } sld_pins_t;

endpackage

// ### hdl/sld_fifo.sv
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 32
) (
  // Clock, reset and flush.
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Filling side.
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Draining side.
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      used;
  logic             push;
  logic             load;

  // Handshake terms; the registered output stage refills when it is empty or drained.
  assign inReady = (used != (AW+1)'(DEPTH));
  assign push    = inValid & inReady;
  assign load    = (used != '0) & (~outValid | outReady);

  // Storage writes.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      used  <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (load) begin
        rdPtr <= rdPtr + AW'(1);
      end
      used <= used + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Read data always leave from a register.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (load) begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule

// ### verif/sld_receiver_assertions.sv
`timescale 1ns/1ps
module sld_receiver_checker #(
  parameter int LANES       = sld_pkg::WIDE_LANES,
  parameter int LOCK_CYCLES = sld_pkg::LOCK_CYCLES,
  parameter int CLOCK_LOST  = sld_pkg::CLOCK_LOST_CYCLES,
  parameter int W           = sld_pkg::BITS_PER_CLOCK * LANES
) (
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         rst_n,
  // Watched ports.
  input wire logic         forwarded_clock_in,
  input wire logic         sleep_n,
  input wire logic [W-1:0] parallel_word_out,
  input wire logic         regenerated_clock_out,
  input wire logic         link_locked
);
  logic [31:0] awakeCnt;
  logic [31:0] stuckCnt;
  logic        lastClk;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Counts the cycles since sleep was released.
  always_ff @(posedge sys_clk) begin
    awakeCnt <= (!rst_n || !sleep_n) ? 32'h0 : awakeCnt + 32'h1;
  end
  // Counts the cycles since the link clock pin last moved.
  always_ff @(posedge sys_clk) begin
    lastClk <= forwarded_clock_in;
    stuckCnt <= (!rst_n || forwarded_clock_in != lastClk) ? 32'h0 : stuckCnt + 32'h1;
  end
  // A link clock rise while locked, then the strobe three cycles on.
  sequence s_rise;
    $rose(forwarded_clock_in) && link_locked && sleep_n;
  endsequence
  sequence s_strobe;
    ##3 ($rose(regenerated_clock_out) || !link_locked || !sleep_n);
  endsequence
  a_strobe_latency: assert property (s_rise |-> s_strobe)
    else $error("strobe late");
  a_strobe_stable: assert property (
    $rose(regenerated_clock_out) && link_locked && sleep_n |-> $stable(parallel_word_out)[*2])
    else $error("word moved at strobe");
  a_word_on_fall: assert property ($changed(parallel_word_out) && link_locked |->
    $past(regenerated_clock_out, 2) && !$past(regenerated_clock_out))
    else $error("word moved off the falling edge");
  a_sleep_clears: assert property ($fell(sleep_n) |-> ##3
    (parallel_word_out == '0 && !regenerated_clock_out && !link_locked))
    else $error("sleep entry slow");
  a_sleep_holds: assert property (!sleep_n [*4] |-> parallel_word_out == '0)
    else $error("word not low in sleep");
  a_lock_wait: assert property ($rose(link_locked) |-> awakeCnt > LOCK_CYCLES)
    else $error("lock too early");
  a_lost_clock: assert property (stuckCnt > CLOCK_LOST + 6 |->
    !regenerated_clock_out && !link_locked)
    else $error("lost clock not seen");
  a_unlocked_hold: assert property (
    !link_locked && sleep_n && $past(sleep_n) |-> $stable(parallel_word_out))
    else $error("word moved while unlocked");
endmodule
bind sld_receiver sld_receiver_checker #(
  .LANES(LANES), .LOCK_CYCLES(LOCK_CYCLES), .CLOCK_LOST(CLOCK_LOST)
) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .forwarded_clock_in(forwarded_clock_in),
  .sleep_n(sleep_n), .parallel_word_out(parallel_word_out),
  .regenerated_clock_out(regenerated_clock_out), .link_locked(link_locked)
);

// ### verif/sld_tx_model.sv
`timescale 1ns/1ps
module sld_tx_model (
  // System clock and controls.
  input  wire logic        sys_clk,
  input  wire logic        run,
  input  wire logic        floatLanes,
  input  wire logic [27:0] word,
  // Link pins.
  output logic             linkClk,
  output logic [3:0]       lanes
);
  logic [2:0]  slot = 3'h0;
  logic [27:0] held = 28'h0;
  int          bitIdx;
  initial linkClk = 1'b1;
  initial lanes = 4'hF;
  // Eight cycles a period, clock high for four; released pins float high.
  always @(negedge sys_clk) begin
    bitIdx = ((2 * int'(slot) + 1) * 7) / 16;
    if (slot == 3'h0) held = word;
    linkClk <= !run || slot < 3'h4;
    for (int l = 0; l < 4; l++) lanes[l] <= !run || floatLanes || held[l*7+bitIdx];
    slot <= run ? slot + 3'h1 : 3'h0;
  end
endmodule

// ### verif/sld_receiver_bench.sv
`timescale 1ns/1ps
module sld_receiver_bench;
  import sld_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sleep_n = 1'b0;
  logic        run = 1'b0;
  logic        floatLanes = 1'b0;
  logic [27:0] word = 28'h0;
  logic        linkClk;
  logic [3:0]  lanes;
  logic [27:0] wide;
  logic [20:0] narrow;
  logic        regen;
  logic        locked;
  int          errorCnt = 0;
  int          nCompared = 0;
  logic [27:0] pat [4] = '{28'h0000001, 28'h8000000, 28'hA5C3E17, 28'h0F0F0F0};
  // Transmitter model and both receiver variants.
  sld_tx_model tx (.sys_clk(sys_clk), .run(run), .floatLanes(floatLanes), .word(word),
    .linkClk(linkClk), .lanes(lanes));
  sld_receiver #(.LANES(WIDE_LANES), .LOCK_CYCLES(40)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .forwarded_clock_in(linkClk), .serial_lane_in(lanes), .sleep_n(sleep_n),
    .parallel_word_out(wide), .regenerated_clock_out(regen), .link_locked(locked));
  sld_receiver #(.LANES(NARROW_LANES), .LOCK_CYCLES(40)) uutNarrow (.sys_clk(sys_clk),
    .rst_n(rst_n), .forwarded_clock_in(linkClk), .serial_lane_in(lanes[2:0]),
    .sleep_n(sleep_n), .parallel_word_out(narrow), .regenerated_clock_out(),
    .link_locked());
  // System clock.
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    $display("Compared %0d, errors %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bounded wait for a level; running out ends the run.
  // The first argument picks the lock flag when high, the regenerated clock when low.
  task automatic waitFor(input logic onLock, input logic val);
    int i;
    for (i = 0; i < 200 && (onLock ? locked : regen) !== val; i++) @(negedge sys_clk);
    if (i == 200) begin
      errorCnt++;
      giveVerdict();
    end
  endtask
  // Sends a word, then judges it at a later strobe.
  task automatic sendWord(input logic [27:0] w, input logic [27:0] e);
    word <= w;
    repeat (40) @(negedge sys_clk);
    waitFor(1'b0, 1'b0);
    waitFor(1'b0, 1'b1);
    check(wide, e);
    check({7'h0, narrow}, {7'h0, e[20:0]});
  endtask
  // Scenario: lock after reset, then the fixed patterns on both variants.
  task automatic runPatterns();
    waitFor(1'b1, 1'b1);
    foreach (pat[i]) sendWord(pat[i], pat[i]);
  endtask
  // Scenario: floating lanes under a running clock read as all ones.
  task automatic runFailsafe();
    floatLanes <= 1'b1;
    sendWord(28'h1234567, 28'hFFFFFFF);
    floatLanes <= 1'b0;
    sendWord(28'h7654321, 28'h7654321);
  endtask
  // Scenario: the clock stops, the word is held, clock and lock drop, then relock.
  task automatic runLostClock();
    run <= 1'b0;
    repeat (CLOCK_LOST_CYCLES + 20) @(negedge sys_clk);
    check(wide, 28'h7654321);
    check({26'h0, regen, locked}, 28'h0);
    run <= 1'b1;
    waitFor(1'b1, 1'b1);
    sendWord(28'hC3C3C3C, 28'hC3C3C3C);
  endtask
  // Scenario: sleep clears the outputs within a microsecond, then wake and relock.
  task automatic runSleep();
    sleep_n <= 1'b0;
    repeat (20) @(negedge sys_clk);
    check(wide, 28'h0);
    check({26'h0, regen, locked}, 28'h0);
    sleep_n <= 1'b1;
    waitFor(1'b1, 1'b1);
    sendWord(28'h3C3C3C3, 28'h3C3C3C3);
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n <= 1'b1;
    sleep_n <= 1'b1;
    run <= 1'b1;
    runPatterns();
    runFailsafe();
    runLostClock();
    runSleep();
    giveVerdict();
  end
endmodule
